// [ivd_dispatch.sv]
// vector dispatch sequencer with wishbone control registers
//
// Notes on behaviour
// - second word bit 0 is stack change flag; bits 1-15 vector table base.
// - a vector entry is one word: direct flag bit 0, target bits 1-15.
// - acknowledge for device code, add to table base, fetch that entry.
// - direct flag 0 jumps to entry target at once, saving nothing.
// - direct flag 1 makes entry the control table; stack flag 0 skips switch.
// - stack flag 1 sets up new stack via location 4, pushes 40-43 octal.
// - push flag 1 pushes return block ending with location 0 bits 1-15.
// - control table address goes to accumulator two, bit 0 cleared.
// - push old mask, OR in table word two, store in acc zero and loc 5.
// - issue mask load to peripherals that also enables interrupts.
// - finally load handler address from table word one into program counter.
// - mode A if direct 0; else stack/push 00 B, 01 C, 10 D, 11 E.
// - locations 4-7 hold stack pointer, mask, stack limit, fault handler.
`include "ivd_map.svh"

module ivd_dispatch
  import ivd_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // memory master
  output logic             mem_req,
  output logic             mem_we,
  output logic      [14:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  // device code acknowledge on the i/o bus
  output logic             acknowledge_device_code_read,
  input  wire logic        dev_code_valid,
  input  wire logic [5:0]  dev_code,
  // mask out to all peripherals
  output logic             mask_out_stb,
  output logic             mask_out_int_on,
  output logic      [15:0] mask_out_data,
  // processor state seen and set
  input  wire logic [15:0] acc0_in,
  input  wire logic [15:0] acc1_in,
  input  wire logic [15:0] acc2_in,
  input  wire logic [15:0] acc3_in,
  input  wire logic        carry_in,
  output logic             pc_load,
  output logic      [14:0] pc_value,
  output logic      [15:0] accumulator_zero,
  output logic      [15:0] accumulator_two,
  output logic             acc_load
);

  // ****************************************************************
  // state
  // ****************************************************************
  ivd_state_e     st_q, st_d, ret_q, ret_d;
  ivd_mode_e      mode_q, mode_d;
  ivd_word_t      word2_q, word2_d;
  logic [14:0]    addr_q, addr_d, sp_q, sp_d, dct_q, dct_d;
  ivd_word_t      dct0_q, dct0_d;
  ivd_word_t      prm_q [4];
  ivd_word_t      prm_d [4];
  ivd_word_t      pbuf_q [5];
  ivd_word_t      pbuf_d [5];
  logic [2:0]     idx_q, idx_d, n_q, n_d;
  logic [14:0]    pc_q, pc_d;
  logic           pcl_q, pcl_d, accl_q, accl_d;
  ivd_word_t      ac0_q, ac0_d, ac2_q, ac2_d;
  logic           fault_q, fault_d;
  logic           ack_q, ack_d;
  logic [31:0]    rdat_q, rdat_d;
  logic           wr_ok, go;
  logic [14:0]    sp_next;

  // ****************************************************************
  // wishbone slave
  // ****************************************************************

  // a write lands only on the first cycle of the strobe
  assign wr_ok = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign go    = wr_ok & (wb_adr_i == `IVD_REG_CTRL) & wb_sel_i[2]
               & wb_dat_i[`IVD_CTRL_START] & (st_q == IVD_IDLE);

  // unmapped offsets answer with zero data rather than stalling
  always_comb begin
    ack_d   = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d  = 32'h0000_0000;
    word2_d = word2_q;
    if (wr_ok && wb_adr_i == `IVD_REG_CTRL && st_q == IVD_IDLE) begin
      if (wb_sel_i[0]) word2_d[7:0]  = wb_dat_i[7:0];
      if (wb_sel_i[1]) word2_d[15:8] = wb_dat_i[15:8];
    end
    unique case (wb_adr_i)
      `IVD_REG_CTRL:   rdat_d[15:0] = word2_q;
      `IVD_REG_STATUS: begin
        rdat_d[`IVD_ST_BUSY]  = (st_q != IVD_IDLE);
        rdat_d[`IVD_ST_FAULT] = fault_q;
        rdat_d[`IVD_ST_MODE_LO +: 3] = mode_q;
      end
      `IVD_REG_PC:     rdat_d[14:0] = pc_q;
      `IVD_REG_ACC0:   rdat_d[15:0] = ac0_q;
      `IVD_REG_ACC2:   rdat_d[15:0] = ac2_q;
      default:         rdat_d = 32'h0000_0000;
    endcase
  end

  // register stage of the bus slave
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
      word2_q <= `IVD_RST_WORD;
    end else begin
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      word2_q <= word2_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************************************
  // handshake outputs
  // ****************************************************************
  assign acknowledge_device_code_read = (st_q == IVD_ACK);
  assign mem_req  = (st_q == IVD_VEC) | (st_q == IVD_PRM)
                  | (st_q == IVD_SAV) | (st_q == IVD_PSH)
                  | (st_q == IVD_DC0) | (st_q == IVD_LC0)
                  | (st_q == IVD_DC1) | (st_q == IVD_WMK)
                  | (st_q == IVD_WSP);
  assign mem_we   = (st_q == IVD_PSH) | (st_q == IVD_WMK) | (st_q == IVD_WSP);
  assign mem_addr = addr_q;
  assign mask_out_stb    = (st_q == IVD_MSK);
  assign mask_out_int_on = (st_q == IVD_MSK);
  assign mask_out_data   = ac0_q;
  assign sp_next  = sp_q + 15'h0001;

  // write data picks from flops only
  always_comb begin
    mem_wdata = pbuf_q[idx_q];
    if (st_q == IVD_WMK) mem_wdata = ac0_q;
    if (st_q == IVD_WSP) mem_wdata = {1'b0, sp_q};
  end

  // ****************************************************************
  // dispatch sequencer
  // ****************************************************************

  // each memory state holds its request until the memory acknowledges
  always_comb begin
    logic go_push;
    go_push = 1'b0;
    st_d = st_q;    ret_d = ret_q;   mode_d = mode_q;
    addr_d = addr_q; sp_d = sp_q;    dct_d = dct_q;   dct0_d = dct0_q;
    prm_d = prm_q;  pbuf_d = pbuf_q; idx_d = idx_q;   n_d = n_q;
    pc_d = pc_q;    pcl_d = 1'b0;    accl_d = 1'b0;
    ac0_d = ac0_q;  ac2_d = ac2_q;   fault_d = fault_q;
    unique case (st_q)
      IVD_IDLE: begin
        if (go) begin
          fault_d = 1'b0;
          st_d    = IVD_ACK;
        end
      end
      IVD_ACK: begin
        if (dev_code_valid) begin
          addr_d = word2_q[14:0] + {9'h000, dev_code};
          st_d   = IVD_VEC;
        end
      end
      IVD_VEC: begin
        if (mem_ack) begin
          if (!mem_rdata[`IVD_FLAG_BIT]) begin
            mode_d = IVD_MODE_A;
            pc_d   = mem_rdata[14:0];
            pcl_d  = 1'b1;
            st_d   = IVD_IDLE;
          end else begin
            dct_d  = mem_rdata[14:0];
            addr_d = `IVD_LOC_SP;
            idx_d  = 3'h0;
            st_d   = IVD_PRM;
          end
        end
      end
      IVD_PRM: begin
        if (mem_ack) begin
          prm_d[idx_q[1:0]] = mem_rdata;
          addr_d = addr_q + 15'h0001;
          idx_d  = idx_q + 3'h1;
          if (idx_q[1:0] == `IVD_PRM_WORDS) begin
            sp_d = prm_q[0][14:0];
            if (word2_q[`IVD_FLAG_BIT]) begin
              addr_d = `IVD_LOC_USTACK;
              idx_d  = 3'h0;
              st_d   = IVD_SAV;
            end else begin
              addr_d = dct_q;
              st_d   = IVD_DC0;
            end
          end
        end
      end
      IVD_SAV: begin
        if (mem_ack) begin
          pbuf_d[idx_q] = mem_rdata;
          addr_d = addr_q + 15'h0001;
          idx_d  = idx_q + 3'h1;
          if (idx_q + 3'h1 == `IVD_USTACK_WORDS) begin
            n_d     = `IVD_USTACK_WORDS;
            ret_d   = IVD_DC0;
            go_push = 1'b1;
          end
        end
      end
      IVD_PSH: begin
        if (mem_ack) begin
          sp_d  = addr_q;
          idx_d = idx_q + 3'h1;
          if (idx_q + 3'h1 == n_q) begin
            st_d = ret_q;
            if (ret_q == IVD_DC0) addr_d = dct_q;
            if (ret_q == IVD_DC1) addr_d = dct_q + 15'h0001;
            if (ret_q == IVD_WMK) addr_d = `IVD_LOC_SP + 15'h0001;
          end else begin
            addr_d = addr_q + 15'h0001;
            if (addr_q + 15'h0001 > prm_q[2][14:0]) st_d = IVD_FLT;
          end
        end
      end
      IVD_DC0: begin
        if (mem_ack) begin
          dct0_d = mem_rdata;
          unique case ({word2_q[`IVD_FLAG_BIT], mem_rdata[`IVD_FLAG_BIT]})
            2'b00: mode_d = IVD_MODE_B;
            2'b01: mode_d = IVD_MODE_C;
            2'b10: mode_d = IVD_MODE_D;
            2'b11: mode_d = IVD_MODE_E;
          endcase
          if (mem_rdata[`IVD_FLAG_BIT]) begin
            addr_d = `IVD_LOC_RETURN;
            st_d   = IVD_LC0;
          end else begin
            addr_d = dct_q + 15'h0001;
            st_d   = IVD_DC1;
          end
        end
      end
      IVD_LC0: begin
        if (mem_ack) begin
          pbuf_d[0] = acc0_in;
          pbuf_d[1] = acc1_in;
          pbuf_d[2] = acc2_in;
          pbuf_d[3] = acc3_in;
          pbuf_d[4] = {carry_in, mem_rdata[14:0]};
          n_d     = `IVD_RET_WORDS;
          ret_d   = IVD_DC1;
          go_push = 1'b1;
        end
      end
      IVD_DC1: begin
        ac2_d = {1'b0, dct_q};
        if (mem_ack) begin
          ac0_d     = mem_rdata | prm_q[1];
          pbuf_d[0] = prm_q[1];
          n_d       = 3'h1;
          ret_d     = IVD_WMK;
          go_push   = 1'b1;
        end
      end
      IVD_WMK: begin
        if (mem_ack) begin
          addr_d = `IVD_LOC_SP;
          st_d   = IVD_WSP;
        end
      end
      IVD_WSP: begin
        if (mem_ack) begin
          accl_d = 1'b1;
          st_d   = IVD_MSK;
        end
      end
      IVD_MSK: st_d = IVD_JMP;
      IVD_JMP: begin
        pc_d  = dct0_q[14:0];
        pcl_d = 1'b1;
        st_d  = IVD_IDLE;
      end
      IVD_FLT: begin
        pc_d    = prm_q[3][14:0];
        pcl_d   = 1'b1;
        fault_d = 1'b1;
        st_d    = IVD_IDLE;
      end
      default: st_d = IVD_IDLE;
    endcase
    // common entry to the push loop with the limit check up front
    if (go_push) begin
      idx_d  = 3'h0;
      addr_d = sp_next;
      st_d   = (sp_next > prm_q[2][14:0]) ? IVD_FLT : IVD_PSH;
    end
  end

  // register stage of the sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= IVD_IDLE;
      ret_q   <= IVD_IDLE;
      mode_q  <= IVD_MODE_A;
      addr_q  <= `IVD_RST_ADDR;
      sp_q    <= `IVD_RST_ADDR;
      dct_q   <= `IVD_RST_ADDR;
      dct0_q  <= `IVD_RST_WORD;
      for (int i = 0; i < 4; i++) prm_q[i] <= `IVD_RST_WORD;
      for (int i = 0; i < 5; i++) pbuf_q[i] <= `IVD_RST_WORD;
      idx_q   <= 3'h0;
      n_q     <= 3'h0;
      pc_q    <= `IVD_RST_ADDR;
      pcl_q   <= 1'b0;
      accl_q  <= 1'b0;
      ac0_q   <= `IVD_RST_WORD;
      ac2_q   <= `IVD_RST_WORD;
      fault_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      ret_q   <= ret_d;
      mode_q  <= mode_d;
      addr_q  <= addr_d;
      sp_q    <= sp_d;
      dct_q   <= dct_d;
      dct0_q  <= dct0_d;
      prm_q   <= prm_d;
      pbuf_q  <= pbuf_d;
      idx_q   <= idx_d;
      n_q     <= n_d;
      pc_q    <= pc_d;
      pcl_q   <= pcl_d;
      accl_q  <= accl_d;
      ac0_q   <= ac0_d;
      ac2_q   <= ac2_d;
      fault_q <= fault_d;
    end
  end

  // results to the processor core
  assign pc_load          = pcl_q;
  assign pc_value         = pc_q;
  assign accumulator_zero = ac0_q;
  assign accumulator_two  = ac2_q;
  assign acc_load         = accl_q;

endmodule

// [ivd_map.svh]
// register offsets, field positions and memory locations of the dispatcher
`ifndef IVD_MAP_SVH
`define IVD_MAP_SVH

// ****************************************************************
// wishbone register byte offsets
// ****************************************************************
`define IVD_REG_CTRL     8'h00
`define IVD_REG_STATUS   8'h04
`define IVD_REG_PC       8'h08
`define IVD_REG_ACC0     8'h0C
`define IVD_REG_ACC2     8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define IVD_CTRL_START   16
`define IVD_FLAG_BIT     15
`define IVD_ST_BUSY      0
`define IVD_ST_FAULT     1
`define IVD_ST_MODE_LO   4

// ****************************************************************
// fixed memory locations
// ****************************************************************
`define IVD_LOC_RETURN   15'h0000
`define IVD_LOC_SP       15'h0004
`define IVD_LOC_USTACK   15'h0020
`define IVD_USTACK_WORDS 3'h4
`define IVD_RET_WORDS    3'h5
`define IVD_PRM_WORDS    2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define IVD_RST_WORD     16'h0000
`define IVD_RST_ADDR     15'h0000

`endif

// [ivd_pkg.sv]
// types shared by the vector dispatch sequencer
package ivd_pkg;

  // ****************************************************************
  // sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [13:0] {
    IVD_IDLE = 14'h0001,
    IVD_ACK  = 14'h0002,
    IVD_VEC  = 14'h0004,
    IVD_PRM  = 14'h0008,
    IVD_SAV  = 14'h0010,
    IVD_PSH  = 14'h0020,
    IVD_DC0  = 14'h0040,
    IVD_LC0  = 14'h0080,
    IVD_DC1  = 14'h0100,
    IVD_WMK  = 14'h0200,
    IVD_WSP  = 14'h0400,
    IVD_MSK  = 14'h0800,
    IVD_JMP  = 14'h1000,
    IVD_FLT  = 14'h2000
  } ivd_state_e;

  // ****************************************************************
  // dispatch modes
  // ****************************************************************
  typedef enum logic [2:0] {
    IVD_MODE_A = 3'h0,
    IVD_MODE_B = 3'h1,
    IVD_MODE_C = 3'h2,
    IVD_MODE_D = 3'h3,
    IVD_MODE_E = 3'h4
  } ivd_mode_e;

  typedef logic [15:0] ivd_word_t;

endpackage

// [ivd_dispatch_sva.sv]
// assertion checker for the vector dispatch sequencer
module ivd_dispatch_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // memory and i/o bus
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [14:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_ack,
  input wire logic        acknowledge_device_code_read,
  input wire logic        dev_code_valid,
  // results
  input wire logic        mask_out_stb,
  input wire logic        mask_out_int_on,
  input wire logic [15:0] mask_out_data,
  input wire logic        pc_load,
  input wire logic [14:0] pc_value,
  input wire logic [15:0] accumulator_zero,
  input wire logic [15:0] accumulator_two,
  input wire logic        acc_load
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        vec_q;
  logic [14:0] dct_q;
  logic [15:0] lim_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // helper tracking
  // ****************
  // entry fetch, table address and stack limit, seen only at the ports
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_q <= 1'b0;
      dct_q <= 15'h0000;
      lim_q <= 16'h0000;
    end else begin
      if (dev_code_valid && acknowledge_device_code_read)
        vec_q <= 1'b1;
      else if (mem_ack)
        vec_q <= 1'b0;
      if (vec_q && mem_ack)
        dct_q <= mem_rdata[14:0];
      if (mem_req && !mem_we && mem_addr == 15'h0006 && mem_ack)
        lim_q <= mem_rdata;
    end
  end
  a_wb_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("wishbone request not answered next cycle");
  a_code_hold:
    assert property (acknowledge_device_code_read && !dev_code_valid
      |=> acknowledge_device_code_read)
    else $error("code acknowledge dropped early");
  a_entry_read:
    assert property (dev_code_valid && acknowledge_device_code_read
      |=> mem_req && !mem_we)
    else $error("vector entry not fetched after device code");
  a_direct_jump:
    assert property (vec_q && mem_ack && !mem_rdata[15]
      |=> pc_load && pc_value == $past(mem_rdata[14:0]))
    else $error("direct entry did not jump at once");
  a_acc2_form:
    assert property (acc_load |-> accumulator_two == {1'b0, dct_q})
    else $error("accumulator two not table address");
  a_mask_out:
    assert property (mask_out_stb |-> mask_out_int_on
      && mask_out_data == accumulator_zero && acc_load)
    else $error("mask out wrong");
  a_handler_jump:
    assert property (mask_out_stb |-> ##[1:4] pc_load)
    else $error("no handler jump after mask out");
  a_stack_limit:
    assert property (mem_req && mem_we && mem_addr > 15'h0005
      |-> {1'b0, mem_addr} <= lim_q)
    else $error("push beyond stack limit");
endmodule

bind ivd_dispatch ivd_dispatch_sva i_ivd_dispatch_sva (
  .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mem_req, .mem_we,
  .mem_addr, .mem_rdata, .mem_ack, .acknowledge_device_code_read,
  .dev_code_valid, .mask_out_stb, .mask_out_int_on, .mask_out_data,
  .pc_load, .pc_value, .accumulator_zero, .accumulator_two, .acc_load);

// [ivd_mem_model.sv]
// memory and interrupting peripheral model facing the dispatcher
module ivd_mem_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // memory slave
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [14:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack,
  // device code answer
  input  wire logic        code_req,
  output logic             dev_code_valid,
  output logic      [5:0]  dev_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];   // low words only, tables kept small
  int          wait_cyc;    // answer delay, set by the bench
  logic [5:0]  code = 6'h05;
  int          cnt;
  // answer after wait_cyc cycles; idle lines toggle so stale data never passes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      dev_code_valid <= 1'b0;
      mem_rdata <= 16'h0000;
      dev_code <= 6'h00;
      cnt <= 0;
    end else begin
      mem_ack <= 1'b0;
      dev_code_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      dev_code <= ~dev_code;
      if ((mem_req || code_req) && !mem_ack && !dev_code_valid) begin
        if (cnt < wait_cyc) begin
          cnt <= cnt + 1;
        end else begin
          cnt <= 0;
          if (mem_req) begin
            mem_ack <= 1'b1;
            if (mem_we)
              mem[mem_addr[7:0]] <= mem_wdata;
            else
              mem_rdata <= mem[mem_addr[7:0]];
          end else begin
            dev_code_valid <= 1'b1;
            dev_code <= code;
          end
        end
      end
    end
  end
endmodule

// [ivd_dispatch_bench.sv]
// self-checking bench for the vector dispatch sequencer
`include "ivd_map.svh"

module ivd_dispatch_bench
  import ivd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic      stk;
    logic      dir;
    logic      psh;
    int        wt;
    ivd_mode_e md;
  } ivd_row_s;
  logic        ref_clk, rst_n, carry_in, wb_cyc_i, wb_stb_i, wb_we_i;
  logic        wb_ack_o, mem_req, mem_we, mem_ack, dev_code_valid;
  logic        acknowledge_device_code_read, mask_out_stb, mask_out_int_on;
  logic        pc_load, acc_load;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [14:0] mem_addr, pc_value;
  logic [15:0] mem_wdata, mem_rdata, mask_out_data, accumulator_zero;
  logic [15:0] accumulator_two, acc0_in, acc1_in, acc2_in, acc3_in;
  logic [5:0]  dev_code;
  int          fails, checked;
  // mode A carries the stack flag to show it is never looked at
  ivd_row_s rows [5] = '{'{1'b1, 1'b0, 1'b1, 2, IVD_MODE_A},
    '{1'b0, 1'b1, 1'b0, 1, IVD_MODE_B}, '{1'b0, 1'b1, 1'b1, 0, IVD_MODE_C},
    '{1'b1, 1'b1, 1'b0, 3, IVD_MODE_D}, '{1'b1, 1'b1, 1'b1, 1, IVD_MODE_E}};
  ivd_dispatch i_ivd_dispatch (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .acknowledge_device_code_read, .dev_code_valid, .dev_code,
    .mask_out_stb, .mask_out_int_on, .mask_out_data, .acc0_in, .acc1_in,
    .acc2_in, .acc3_in, .carry_in, .pc_load, .pc_value, .accumulator_zero,
    .accumulator_two, .acc_load);
  ivd_mem_model mdl (.ref_clk, .rst_n, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .code_req(acknowledge_device_code_read),
    .dev_code_valid, .dev_code);
  // free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, exp, input string msg);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // classic single cycle; waits for ack without assuming its latency,
  // so a slave that never answers is caught by the watchdog alone
  task automatic wb(input logic [7:0] a, input logic we, logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  // one dispatch: tables set, start, a refused restart when the direct flag is 1, then results
  task automatic run(input ivd_row_s r, input logic [15:0] lim);
    int n, k;
    logic ovf;
    logic [15:0] pc;
    n = r.dir + (r.dir && r.stk ? 4 : 0) + (r.dir && r.psh ? 5 : 0);
    ovf = r.dir && (16'h0040 + n > lim);
    for (k = 0; k < 256; k++) mdl.mem[k] = 16'(k);
    mdl.mem[0] = 16'h0ABC;
    mdl.mem[4] = 16'h0040;
    mdl.mem[5] = 16'h00F0;
    mdl.mem[6] = lim;
    mdl.mem[7] = 16'h0077;
    for (k = 0; k < 4; k++) mdl.mem[32 + k] = 16'(16'h1111 * (k + 1));
    mdl.mem[8'h15] = {r.dir, r.dir ? 15'h0080 : 15'h0456};
    mdl.mem[8'h80] = {r.psh, 15'h0123};
    mdl.mem[8'h81] = 16'h0F00;
    mdl.wait_cyc = r.wt;
    wb(`IVD_REG_CTRL, 1'b1, {15'h0000, 1'b1, r.stk, 15'h0010});
    if (r.dir) wb(`IVD_REG_CTRL, 1'b1, 32'h0001_0030);
    // a hung dispatch is left to the watchdog, which counts it as failed
    while (pc_load !== 1'b1) begin
      @(posedge ref_clk);
    end
    pc = {1'b0, pc_value};
    do begin
      wb(`IVD_REG_STATUS, 1'b0, 32'h0);
    end while (q[`IVD_ST_BUSY] !== 1'b0);
    cmp({15'h0000, q[`IVD_ST_FAULT]}, {15'h0000, ovf}, "fault");
    cmp(pc, ovf ? 16'h0077 : r.dir ? 16'h0123 : 16'h0456, "pc");
    if (!ovf) cmp({13'h0000, q[6:4]}, 16'(r.md), "mode");
    if (ovf) cmp(mdl.mem[lim[7:0] + 1], lim + 16'h1, "past limit");
    else if (!r.dir) cmp(mdl.mem[4], 16'h0040, "sp kept");
    else begin
      cmp(mdl.mem[4], 16'(16'h0040 + n), "sp");
      cmp(mdl.mem[5], 16'h0FF0, "mask");
      cmp(mdl.mem[64 + n], 16'h00F0, "old mask");
      cmp(mdl.mem[65], r.stk ? 16'h1111 : r.psh ? acc0_in : 16'h00F0,
        "first push");
      if (r.psh) cmp(mdl.mem[63 + n], {carry_in, 15'h0ABC}, "ret");
      wb(`IVD_REG_ACC0, 1'b0, 32'h0);
      cmp(q[15:0], 16'h0FF0, "acc0");
      wb(`IVD_REG_ACC2, 1'b0, 32'h0);
      cmp(q[15:0], 16'h0080, "acc2");
      wb(`IVD_REG_CTRL, 1'b0, 32'h0);
      cmp(q[15:0], {r.stk, 15'h0010}, "ctrl kept");
    end
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    {wb_adr_i, wb_dat_i} = 40'h0;
    wb_sel_i = 4'hF;
    carry_in = 1'b1;
    {acc0_in, acc1_in, acc2_in, acc3_in} = 64'hA001_A002_A003_A004;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    cmp({15'h0000, pc_load}, 16'h0000, "pc_load in idle");
    wb(`IVD_REG_STATUS, 1'b1, 32'hFFFF_FFFF);
    wb(`IVD_REG_STATUS, 1'b0, 32'h0);
    cmp(q[15:0], 16'h0000, "status reset");
    wb(8'h40, 1'b1, 32'hFFFF_FFFF);
    wb(8'h40, 1'b0, 32'h0);
    cmp(q[15:0], 16'h0000, "unmapped");
    $display("registers done");
    for (int i = 0; i < 5; i++) begin
      run(rows[i], 16'h0060);
      $display("row %0d done", i);
    end
    run(rows[4], 16'h0045);
    $display("overflow done");
    run(rows[1], 16'h0060);
    $display("fault clear done");
    // reset in the middle of a dispatch must leave the sequencer idle
    wb(`IVD_REG_CTRL, 1'b1, 32'h0001_8010);
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    cmp({15'h0000, pc_load}, 16'h0000, "pc_load after reset");
    wb(`IVD_REG_STATUS, 1'b0, 32'h0);
    cmp(q[15:0], 16'h0000, "status after reset");
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
